// >>> logic/bbt_engine.sv
// bit-boundary block transfer engine: table fetch, line walk, word combine
// Contract
// - without control store present, trap as unimplemented and touch nothing
// - the table pointer accumulator is never changed by the engine
// - table words are read in order zero through fifteen
// - negative width or height completes with no memory change
// - interrupts taken only at line start; progress kept, pc backed up
// - each rectangle placed by base, pitch, left offset, top; width and height given for the destination only
// - control bits select alternate bank for source and destination
// - operation field picks replace, paint, invert or erase
// - source field picks block, complement, block and pattern, pattern
// - one pattern word per line, cycled in processing order
// - vertical direction from top lines; pattern follows that direction
// - source size is the destination size
// - word order keeps overlapping moves correct; caller shares bitmap
module bbt_engine
   import bbt_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic        ram_present,
   input  wire logic        irq_pending,
   output logic             trap_unimpl,
   output logic             pc_backup,
   output logic             op_done,
   output logic             mem_rd,
   output logic             mem_wr,
   output logic             mem_alt,
   output logic      [15:0] mem_addr,
   output logic      [15:0] mem_wdata,
   input  wire logic [15:0] mem_rdata
);
   bbt_state_e  state_q, state_d;
   logic [15:0] tbl_q [BBT_TBL_WORDS];
   logic [3:0]  idx_q;
   logic [15:0] ptr_q, prog_q, wi_q, sa_q, sb_q, rdata_q;
   logic        done_f_q, trap_f_q, intr_f_q;
   logic        trap_q, backup_q, fin_q;

   // register decode
   wire         wr_ptr   = reg_wr && (reg_addr == BBT_OFS_TABLE_PTR);
   wire         wr_prog  = reg_wr && (reg_addr == BBT_OFS_PROGRESS);
   wire         wr_cmd   = reg_wr && (reg_addr == BBT_OFS_COMMAND);
   wire         busy     = (state_q != S_IDLE);
   wire         start    = wr_cmd && reg_wdata[BBT_CMD_START] && !busy;
   wire [15:0]  status_w = {12'h000, intr_f_q, trap_f_q, done_f_q, busy};
   wire [15:0]  rd_mux   = (reg_addr == BBT_OFS_TABLE_PTR) ? ptr_q :
                           (reg_addr == BBT_OFS_PROGRESS)  ? prog_q :
                           (reg_addr == BBT_OFS_STATUS)    ? status_w : 16'h0000;

   // table fields
   wire [15:0]  cw     = tbl_q[BBT_W_CONTROL];
   wire [15:0]  dbase  = tbl_q[BBT_W_DBASE];
   wire [15:0]  dpitch = tbl_q[BBT_W_DPITCH];
   wire [15:0]  dlx    = tbl_q[BBT_W_DLX];
   wire [15:0]  dest_top_line    = tbl_q[BBT_W_DTY];
   wire [15:0]  dw     = tbl_q[BBT_W_DW];
   wire [15:0]  dh     = tbl_q[BBT_W_DH];
   wire [15:0]  sbase  = tbl_q[BBT_W_SBASE];
   wire [15:0]  spitch = tbl_q[BBT_W_SPITCH];
   wire [15:0]  slx    = tbl_q[BBT_W_SLX];
   wire [15:0]  src_top_line    = tbl_q[BBT_W_STY];
   wire [1:0]   op     = cw[BBT_CW_OP_HI:BBT_CW_OP_LO];
   wire [1:0]   srcsel = cw[BBT_CW_SRC_HI:BBT_CW_SRC_LO];

   // walk direction and empty-rectangle test
   wire         top_down = $signed(dest_top_line) <= $signed(src_top_line);
   wire         rtl      = $signed(dlx) > $signed(slx);
   wire         empty    = ($signed(dw) <= 0) || ($signed(dh) <= 0);
   wire         last_ln  = (prog_q >= dh);

   // line addresses from base, pitch and top offset
   wire [15:0]  line_y  = top_down ? prog_q : (dh - 16'h0001 - prog_q);
   wire [15:0]  d_row   = dest_top_line + line_y;
   wire [15:0]  s_row   = src_top_line + line_y;
   wire [31:0]  d_prod  = {16'h0000, d_row} * {16'h0000, dpitch};
   wire [31:0]  s_prod  = {16'h0000, s_row} * {16'h0000, spitch};
   wire [15:0]  d_line  = dbase + d_prod[15:0];
   wire [15:0]  s_line  = sbase + s_prod[15:0];

   // word span of the destination line and the source bit alignment
   wire [15:0]  rbit    = dlx + dw - 16'h0001;
   wire [15:0]  first_w = {4'h0, dlx[15:4]};
   wire [15:0]  last_w  = {4'h0, rbit[15:4]};
   wire [15:0]  start_w = rtl ? last_w : first_w;
   wire [15:0]  end_w   = rtl ? first_w : last_w;
   wire [15:0]  sbit    = {wi_q[11:0], 4'h0} - dlx + slx;
   wire [15:0]  sw      = {{4{sbit[15]}}, sbit[15:4]};
   wire [15:0]  s_addr  = s_line + sw;
   wire [15:0]  d_addr  = d_line + wi_q;
   wire [31:0]  pair    = {sa_q, sb_q} << sbit[3:0];

   // edge masks, msb is the leftmost bit
   wire [15:0]  mask_l  = (wi_q == first_w) ? (16'hffff >> dlx[3:0]) : 16'hffff;
   wire [15:0]  mask_r  = (wi_q == last_w) ? ~(16'h7fff >> rbit[3:0]) : 16'hffff;
   wire [15:0]  mask    = mask_l & mask_r;

   // pattern word chosen by lines processed so far
   wire [15:0]  pat_w   = tbl_q[BBT_W_PATTERN + {30'h0, prog_q[1:0]}];
   wire [15:0]  raw     = pair[31:16];
   wire [15:0]  src_v   = (srcsel == BBT_SRC_BLOCK)   ? raw :
                          (srcsel == BBT_SRC_INV)     ? ~raw :
                          (srcsel == BBT_SRC_AND_PAT) ? (raw & pat_w) : pat_w;
   wire [15:0]  dst_v   = mem_rdata;
   wire [15:0]  res_v   = (op == BBT_OP_REPLACE) ? src_v :
                          (op == BBT_OP_PAINT)   ? (src_v | dst_v) :
                          (op == BBT_OP_INVERT)  ? (src_v ^ dst_v) : (~src_v & dst_v);

   // memory request drive; read data come back one cycle after the request,
   // so every read state is followed by a state that consumes what it asked for
   assign mem_rd    = (state_q == S_FETCH) || (state_q == S_SA) ||
                      (state_q == S_SB) || (state_q == S_DR);
   assign mem_wr    = (state_q == S_DW);
   assign mem_alt   = ((state_q == S_SA) || (state_q == S_SB)) ? cw[BBT_CW_SRC_ALT] :
                      ((state_q == S_DR) || (state_q == S_DW)) ? cw[BBT_CW_DST_ALT] :
                      1'b0;
   assign mem_addr  = (state_q == S_FETCH) ? (ptr_q + {12'h000, idx_q}) :
                      (state_q == S_SA)    ? s_addr :
                      (state_q == S_SB)    ? (s_addr + 16'h0001) : d_addr;
   assign mem_wdata = (res_v & mask) | (dst_v & ~mask);
   assign reg_rdata   = rdata_q;
   assign trap_unimpl = trap_q;
   assign pc_backup   = backup_q;
   assign op_done     = fin_q;

   // next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         S_IDLE:  if (start && ram_present) state_d = S_FETCH;
         S_FETCH: state_d = S_FCAP;
         S_FCAP:  state_d = (idx_q == 4'hf) ? S_CHECK : S_FETCH;
         S_CHECK: state_d = (empty || last_ln) ? S_IDLE : S_LINE;
         S_LINE:  state_d = irq_pending ? S_IDLE : S_WORD;
         S_WORD:  state_d = (srcsel == BBT_SRC_PATTERN) ? S_DR : S_SA;
         S_SA:    state_d = S_SB;
         S_SB:    state_d = S_DR;
         S_DR:    state_d = S_DW;
         S_DW:    state_d = (wi_q == end_w) ? S_LEND : S_WORD;
         S_LEND:  state_d = S_CHECK;
         default: state_d = S_IDLE;
      endcase
   end

   // state, table capture and word walk
   always_ff @(posedge clock) begin
      if (reset) begin
         state_q <= S_IDLE;
         idx_q   <= 4'h0;
         wi_q    <= 16'h0000;
         sa_q    <= 16'h0000;
         sb_q    <= 16'h0000;
      end else begin
         state_q <= state_d;
         if (start) idx_q <= 4'h0;
         if (state_q == S_FCAP) begin
            tbl_q[idx_q] <= mem_rdata;
            idx_q        <= idx_q + 4'h1;
         end
         if (state_q == S_LINE) wi_q <= start_w;
         if (state_q == S_DW) wi_q <= rtl ? (wi_q - 16'h0001) : (wi_q + 16'h0001);
         if (state_q == S_SB) sa_q <= mem_rdata;
         if (state_q == S_DR) sb_q <= mem_rdata;
      end
   end

   // accumulators: pointer only written by software, progress saved per line
   always_ff @(posedge clock) begin
      if (reset) begin
         ptr_q  <= BBT_PTR_RESET;
         prog_q <= BBT_PROG_RESET;
      end else begin
         if (wr_ptr && !busy) ptr_q <= reg_wdata;
         if (wr_prog && !busy) prog_q <= reg_wdata;
         if (state_q == S_LEND) prog_q <= prog_q + 16'h0001;
         if ((state_q == S_CHECK) && (empty || last_ln)) prog_q <= 16'h0000;
      end
   end

   // status flags, event pulses and read data
   always_ff @(posedge clock) begin
      if (reset) begin
         done_f_q <= 1'b0;
         trap_f_q <= 1'b0;
         intr_f_q <= 1'b0;
         trap_q   <= 1'b0;
         backup_q <= 1'b0;
         fin_q    <= 1'b0;
         rdata_q  <= 16'h0000;
      end else begin
         trap_q   <= start && !ram_present;
         backup_q <= (state_q == S_LINE) && irq_pending;
         fin_q    <= (state_q == S_CHECK) && (empty || last_ln);
         if (start) begin
            done_f_q <= 1'b0;
            trap_f_q <= 1'b0;
            intr_f_q <= 1'b0;
         end
         if (trap_q) trap_f_q <= 1'b1;
         if (backup_q) intr_f_q <= 1'b1;
         if (fin_q) done_f_q <= 1'b1;
         if (reg_rd) rdata_q <= rd_mux;
      end
   end

   // checks on the engine's own behaviour
   a_trap_no_run: assert property (@(posedge clock) disable iff (reset)
      (start && !ram_present) |=> (trap_unimpl && state_q == S_IDLE && !mem_rd))
      else $error("missing store did not trap");
   a_ptr_kept: assert property (@(posedge clock) disable iff (reset)
      busy |=> $stable(ptr_q))
      else $error("table pointer changed by engine");
   a_table_order: assert property (@(posedge clock) disable iff (reset)
      (state_q == S_FETCH) |-> (mem_rd && mem_addr == ptr_q + {12'h000, idx_q}))
      else $error("table word address out of order");
   a_empty_nop: assert property (@(posedge clock) disable iff (reset)
      (state_q == S_CHECK && empty) |=> (!busy && op_done && !mem_wr))
      else $error("empty rectangle not a no-op");
   a_irq_line: assert property (@(posedge clock) disable iff (reset)
      pc_backup |-> ($past(state_q) == S_LINE && state_q == S_IDLE))
      else $error("interrupt taken away from line start");
   a_edge_keep: assert property (@(posedge clock) disable iff (reset)
      mem_wr |-> (((mem_wdata ^ mem_rdata) & ~mask) == 16'h0000))
      else $error("bits outside rectangle changed");
   a_bank_src: assert property (@(posedge clock) disable iff (reset)
      (state_q == S_SA) |-> (mem_alt == cw[BBT_CW_SRC_ALT]) ##1 (mem_alt == cw[BBT_CW_SRC_ALT])
                            ##1 (mem_alt == cw[BBT_CW_DST_ALT]))
      else $error("bank select wrong");
   a_pattern_only: assert property (@(posedge clock) disable iff (reset)
      (state_q == S_WORD && srcsel == BBT_SRC_PATTERN) |=> (state_q == S_DR))
      else $error("pattern source read source memory");
   a_line_step: assert property (@(posedge clock) disable iff (reset)
      (state_q == S_LEND) |=> (prog_q == $past(prog_q) + 16'h0001))
      else $error("progress not advanced per line");

   // word steps: a source-fed word reads two neighbouring source words,
   // then reads and rewrites one destination word at the same address
   sequence s_src_pair;
      (state_q == S_SA && mem_rd) ##1
      (state_q == S_SB && mem_rd && mem_addr == $past(mem_addr) + 16'h0001);
   endsequence
   sequence s_dst_update;
      (state_q == S_DR && mem_rd) ##1 (state_q == S_DW && mem_wr && mem_addr == $past(mem_addr));
   endsequence
   a_word_steps: assert property (@(posedge clock) disable iff (reset)
      (state_q == S_WORD && srcsel != BBT_SRC_PATTERN) |=> s_src_pair ##1 s_dst_update)
      else $error("source word sequence broken");
   a_pattern_steps: assert property (@(posedge clock) disable iff (reset)
      (state_q == S_WORD && srcsel == BBT_SRC_PATTERN) |=> s_dst_update)
      else $error("pattern word sequence broken");

   // start, trap and completion framing
   a_start_fetch: assert property (@(posedge clock) disable iff (reset)
      (start && ram_present) |=> (state_q == S_FETCH && idx_q == 4'h0))
      else $error("table fetch did not begin at word zero");
   a_idle_quiet: assert property (@(posedge clock) disable iff (reset)
      !busy |-> (!mem_rd && !mem_wr))
      else $error("memory touched while idle");
   a_trap_idle: assert property (@(posedge clock) disable iff (reset)
      trap_unimpl |-> !busy)
      else $error("engine ran after a trap");
   a_done_once: assert property (@(posedge clock) disable iff (reset)
      op_done |-> (!busy && prog_q == 16'h0000 && !pc_backup))
      else $error("completion pulse while still working");
   a_prog_hold: assert property (@(posedge clock) disable iff (reset)
      pc_backup |-> (prog_q == $past(prog_q)))
      else $error("progress lost on interrupt");
   a_line_go: assert property (@(posedge clock) disable iff (reset)
      (state_q == S_LINE && !irq_pending) |=> (state_q == S_WORD && wi_q == $past(start_w)))
      else $error("line start did not begin the word walk");

   // result word checks, independent of the selection chain where possible
   a_replace_word: assert property (@(posedge clock) disable iff (reset)
      (mem_wr && op == BBT_OP_REPLACE) |-> (((mem_wdata ^ src_v) & mask) == 16'h0000))
      else $error("replace did not store the source");
   a_paint_word: assert property (@(posedge clock) disable iff (reset)
      (mem_wr && op == BBT_OP_PAINT) |-> ((mem_wdata & mem_rdata) == mem_rdata))
      else $error("paint cleared a destination bit");
   a_erase_word: assert property (@(posedge clock) disable iff (reset)
      (mem_wr && op == BBT_OP_ERASE) |-> ((mem_wdata & ~mem_rdata) == 16'h0000))
      else $error("erase set a destination bit");
   a_pattern_word: assert property (@(posedge clock) disable iff (reset)
      (mem_wr && srcsel == BBT_SRC_PATTERN && op == BBT_OP_REPLACE) |->
      (((mem_wdata ^ tbl_q[BBT_W_PATTERN + int'(prog_q[1:0])]) & mask) == 16'h0000))
      else $error("pattern word out of sequence");
   a_dst_bank: assert property (@(posedge clock) disable iff (reset)
      mem_wr |-> (mem_alt == cw[BBT_CW_DST_ALT]))
      else $error("destination bank wrong on write");
   a_dir_row: assert property (@(posedge clock) disable iff (reset)
      (state_q == S_DW) |->
      (d_row == (top_down ? (dest_top_line + prog_q) : (dest_top_line + dh - 16'h0001 - prog_q))))
      else $error("line order does not follow the walk direction");
endmodule

// >>> logic/bbt_pkg.sv
// constants for the bit-boundary block transfer engine
package bbt_pkg;
   // register byte offsets on the command port
   localparam logic [7:0] BBT_OFS_TABLE_PTR = 8'h00;
   localparam logic [7:0] BBT_OFS_PROGRESS  = 8'h04;
   localparam logic [7:0] BBT_OFS_COMMAND   = 8'h08;
   localparam logic [7:0] BBT_OFS_STATUS    = 8'h0c;
   // command and status bit positions
   localparam int BBT_CMD_START   = 0;
   localparam int BBT_STAT_BUSY   = 0;
   localparam int BBT_STAT_DONE   = 1;
   localparam int BBT_STAT_TRAP   = 2;
   localparam int BBT_STAT_INTR   = 3;
   // reset values
   localparam logic [15:0] BBT_PTR_RESET  = 16'h0000;
   localparam logic [15:0] BBT_PROG_RESET = 16'h0000;
   // parameter table layout (word indices)
   localparam int BBT_TBL_WORDS   = 16;
   localparam int BBT_W_CONTROL   = 0;
   localparam int BBT_W_DBASE     = 2;
   localparam int BBT_W_DPITCH    = 3;
   localparam int BBT_W_DLX       = 4;
   localparam int BBT_W_DTY       = 5;
   localparam int BBT_W_DW        = 6;
   localparam int BBT_W_DH        = 7;
   localparam int BBT_W_SBASE     = 8;
   localparam int BBT_W_SPITCH    = 9;
   localparam int BBT_W_SLX       = 10;
   localparam int BBT_W_STY       = 11;
   localparam int BBT_W_PATTERN   = 12;
   // control word fields, counted from the lsb (msb-first bits 10..15)
   localparam int BBT_CW_SRC_ALT  = 5;
   localparam int BBT_CW_DST_ALT  = 4;
   localparam int BBT_CW_SRC_HI   = 3;
   localparam int BBT_CW_SRC_LO   = 2;
   localparam int BBT_CW_OP_HI    = 1;
   localparam int BBT_CW_OP_LO    = 0;
   // source operand codes
   localparam logic [1:0] BBT_SRC_BLOCK   = 2'h0;
   localparam logic [1:0] BBT_SRC_INV     = 2'h1;
   localparam logic [1:0] BBT_SRC_AND_PAT = 2'h2;
   localparam logic [1:0] BBT_SRC_PATTERN = 2'h3;
   // result operation codes
   localparam logic [1:0] BBT_OP_REPLACE  = 2'h0;
   localparam logic [1:0] BBT_OP_PAINT    = 2'h1;
   localparam logic [1:0] BBT_OP_INVERT   = 2'h2;
   localparam logic [1:0] BBT_OP_ERASE    = 2'h3;
   typedef enum {S_IDLE, S_FETCH, S_FCAP, S_CHECK, S_LINE, S_WORD,
                 S_SA, S_SB, S_DR, S_DW, S_LEND} bbt_state_e;
endpackage

// >>> tb/bbt_engine_tb_top.sv
// self-checking bench for the block transfer engine
module bbt_engine_tb_top;
   import bbt_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] TBL = 16'h0040;
   logic        clock       = 1'b0;
   logic        reset       = 1'b1;
   logic [7:0]  reg_addr    = 8'h00;
   logic [15:0] reg_wdata   = 16'h0000;
   logic        reg_wr      = 1'b0;
   logic        reg_rd      = 1'b0;
   logic        ram_present = 1'b1;
   logic        irq_pending = 1'b0;
   logic [15:0] reg_rdata, mem_addr, mem_wdata, mem_rdata, rd_val;
   logic        trap_unimpl, pc_backup, op_done, mem_rd, mem_wr, mem_alt;
   logic [2:0]  seen = 3'b000;
   logic [15:0] rd_log [$];
   // pattern words already phased for a top-down walk from destination line zero
   logic [15:0] tbl [16] = '{16'h0000, 16'h0000, 16'h0100, 16'h0001, 16'h0000, 16'h0000,
      16'h0010, 16'h0001, 16'h0200, 16'h0001, 16'h0000, 16'h0000,
      16'hff00, 16'h0ff0, 16'h00ff, 16'hf00f};
   // control word, expected main bank word, expected alternate bank word
   logic [47:0] rows [9] = '{48'h0000_cc33_0f0f, 48'h0001_fcf3_0f0f, 48'h0002_3cc3_0f0f,
      48'h0003_30c0_0f0f, 48'h0004_33cc_0f0f, 48'h0008_cc00_0f0f, 48'h000c_ff00_0f0f,
      48'h0020_a5a5_0f0f, 48'h0010_f0f0_cc33};
   int          bad_count = 0;
   int          tests_run = 0;
   int          cycles    = 0;
   int          wr_count  = 0;

   always #2.5 clock = ~clock;

   bbt_engine DUT (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ram_present(ram_present),
      .irq_pending(irq_pending), .trap_unimpl(trap_unimpl), .pc_backup(pc_backup),
      .op_done(op_done), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_alt(mem_alt),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   bbt_mem_model mem (.clock(clock), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_alt(mem_alt),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   // pulse capture, write count, read address log and hang guard
   always @(posedge clock) begin
      cycles++;
      seen = seen | {op_done, pc_backup, trap_unimpl};
      if (mem_wr === 1'b1) wr_count++;
      if (mem_rd === 1'b1) rd_log.push_back(mem_addr);
      if (cycles == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end

   task check(input logic [15:0] seen_v, input logic [15:0] exp_v);
      tests_run++;
      if (seen_v !== exp_v) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen_v, exp_v);
      end
   endtask

   task report_and_stop;
      if (bad_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // one write cycle then one idle cycle
   task reg_write(input logic [7:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask

   task reg_read(input logic [7:0] a, output logic [15:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge clock);
   endtask

   task load_tbl;
      for (int i = 0; i < 16; i++) mem.main_q[TBL[9:0] + 10'(i)] = tbl[i];
   endtask

   task start_op(input bit resume);
      rd_log.delete();
      wr_count = 0;
      seen = 3'b000;
      if (!resume) begin
         reg_write(BBT_OFS_TABLE_PTR, TBL);
         reg_write(BBT_OFS_PROGRESS, 16'h0000);
      end
      reg_write(BBT_OFS_COMMAND, 16'h0001);
   endtask

   // wait for done, backup or trap; order is {done, backup, trap}
   task wait_end(input logic [2:0] exp);
      for (int n = 0; n < 400 && seen == 3'b000; n++) begin
         @(posedge clock);
         #1;
      end
      @(posedge clock);
      check({13'h0000, seen}, {13'h0000, exp});
   endtask

   task run_row(input logic [15:0] ctl);
      tbl[0] = ctl;
      load_tbl();
      mem.main_q[10'h200] = 16'hcc33;
      mem.alt_q[10'h200] = 16'ha5a5;
      mem.main_q[10'h100] = 16'hf0f0;
      mem.alt_q[10'h100] = 16'h0f0f;
      start_op(1'b0);
      wait_end(3'b100);
   endtask

   initial begin
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      // reset values of the accumulators and status
      reg_read(BBT_OFS_TABLE_PTR, rd_val);
      check(rd_val, BBT_PTR_RESET);
      reg_read(BBT_OFS_PROGRESS, rd_val);
      check(rd_val, BBT_PROG_RESET);
      reg_read(BBT_OFS_STATUS, rd_val);
      check(rd_val, 16'h0000);
      // every source code, operation and bank choice
      foreach (rows[i]) begin
         run_row(rows[i][47:32]);
         check(mem.main_q[10'h100], rows[i][31:16]);
         check(mem.alt_q[10'h100], rows[i][15:0]);
      end
      for (int k = 0; k < 16; k++) check(rd_log[k], TBL + 16'(k));
      // missing control store traps with no memory traffic
      ram_present <= 1'b0;
      start_op(1'b0);
      wait_end(3'b001);
      check(16'(wr_count + rd_log.size()), 16'h0000);
      reg_read(BBT_OFS_STATUS, rd_val);
      check(rd_val, 16'h0004);
      ram_present <= 1'b1;
      // negative height is a no-op
      tbl[7] = 16'hffff;
      run_row(16'h0000);
      check(16'(wr_count), 16'h0000);
      check(mem.main_q[10'h100], 16'hf0f0);
      // partial word keeps bits outside the rectangle
      tbl[7] = 16'h0001;
      tbl[4] = 16'h0004;
      tbl[10] = 16'h0004;
      tbl[6] = 16'h0008;
      run_row(16'h0000);
      check(mem.main_q[10'h100], 16'hfc30);
      // overlapping move one line down in one bitmap must run bottom-up
      tbl[4] = 16'h0000;
      tbl[10] = 16'h0000;
      tbl[6] = 16'h0010;
      tbl[8] = 16'h0100;
      tbl[5] = 16'h0001;
      tbl[7] = 16'h0002;
      tbl[0] = 16'h0000;
      load_tbl();
      for (int k = 0; k < 3; k++) mem.main_q[10'h100 + 10'(k)] = 16'h1111 * 16'(k + 1);
      start_op(1'b0);
      wait_end(3'b100);
      check(mem.main_q[10'h101], 16'h1111);
      check(mem.main_q[10'h102], 16'h2222);
      // pattern fill interrupted after line 0, then resumed
      tbl[0] = 16'h000c;
      tbl[5] = 16'h0000;
      tbl[7] = 16'h0003;
      load_tbl();
      for (int k = 0; k < 3; k++) mem.main_q[10'h100 + 10'(k)] = 16'h0000;
      start_op(1'b0);
      for (int n = 0; n < 200 && wr_count == 0; n++) begin
         @(posedge clock);
         #1;
      end
      @(posedge clock);
      irq_pending <= 1'b1;
      wait_end(3'b010);
      reg_read(BBT_OFS_PROGRESS, rd_val);
      check(rd_val, 16'h0001);
      check(mem.main_q[10'h101], 16'h0000);
      check(mem.main_q[10'h100], 16'hff00);
      irq_pending <= 1'b0;
      start_op(1'b1);
      wait_end(3'b100);
      check(mem.main_q[10'h101], 16'h0ff0);
      check(mem.main_q[10'h102], 16'h00ff);
      reg_read(BBT_OFS_TABLE_PTR, rd_val);
      check(rd_val, TBL);
      reg_read(BBT_OFS_STATUS, rd_val);
      check(rd_val, 16'h0002);
      report_and_stop();
   end
endmodule

// >>> tb/bbt_mem_model.sv
// main memory model with a main and an alternate bank, one-cycle read latency
module bbt_mem_model (
   input  wire logic        clock,
   input  wire logic        mem_rd,
   input  wire logic        mem_wr,
   input  wire logic        mem_alt,
   input  wire logic [15:0] mem_addr,
   input  wire logic [15:0] mem_wdata,
   output logic      [15:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] main_q [0:1023];
   logic [15:0] alt_q  [0:1023];
   // read data arrive one cycle later and hold until the next read
   always @(posedge clock) begin
      if (mem_rd)
         mem_rdata <= mem_alt ? alt_q[mem_addr[9:0]] : main_q[mem_addr[9:0]];
      if (mem_wr && mem_alt)
         alt_q[mem_addr[9:0]] <= mem_wdata;
      else if (mem_wr)
         main_q[mem_addr[9:0]] <= mem_wdata;
   end
endmodule
